// *** design/fbm_flash_bank_map.sv ***
/*
 Registered address decoder placing ROM, SRAM, code-flash and work-flash.
 Assumes the request and mode inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "fbm_params.svh"
module fbm_flash_bank_map (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic i_user,
    input wire logic i_dual_bank,
    input wire logic i_map_b,
    output fbm_pkg::fbm_route_s o_route,
    output logic o_valid
);
    import fbm_pkg::*;

    fbm_route_s route_d, route_q;
    logic valid_d, valid_q;

    // ============================================================
    // Decode one region: large then small sectors
    function automatic fbm_route_s sect(input logic [31:0] ofs, input logic [31:0] ss_ofs,
                                        input logic [31:0] end_ofs, input int ls_sh, input int ss_sh);
        fbm_route_s r;
        r = '0;
        if (ofs >= end_ofs) begin
            r.bus_error = 1'b1;
        end else if (ofs < ss_ofs) begin
            r.large_sector = 1'b1;
            r.sector = 8'((ofs >> ls_sh));
        end else begin
            r.sector = 8'(((ofs - ss_ofs) >> ss_sh));
        end
        r.offset = ofs[19:0];
        return r;
    endfunction : sect

    // ============================================================
    // Target decode
    always_comb begin
        logic [31:0] a;
        logic phys;
        a = i_addr;
        phys = 1'b0;
        route_d = '0;
        valid_d = i_req;
        if (a >= `FBM_ROM_BASE && a < `FBM_ROM_BASE + `FBM_ROM_SIZE) begin
            route_d.target = 3'(FBM_T_ROM);
            route_d.offset = a[19:0];
        end else if (a >= `FBM_SRAM_BASE && a < `FBM_SRAM_BASE + `FBM_SRAM_SIZE) begin
            route_d.target = 3'(FBM_T_SRAM);
            route_d.offset = a[19:0];
            // Keep the boot scratch area out of reach of user code
            route_d.bus_error = i_user && (a - `FBM_SRAM_BASE < `FBM_SRAM_RSVD);
        end else if (!i_dual_bank && a >= `FBM_CF_BASE0 && a < `FBM_CF_BASE1) begin
            route_d = sect(a - `FBM_CF_BASE0, `FBM_CF_SS_OFS_SGL, `FBM_CF_END_SGL,
                           `FBM_CF_LS_SHIFT, `FBM_CF_SS_SHIFT);
            route_d.target = 3'(FBM_T_CODE);
        end else if (!i_dual_bank && a >= `FBM_WF_BASE0 && a < `FBM_WF_BASE1) begin
            route_d = sect(a - `FBM_WF_BASE0, `FBM_WF_SS_OFS_SGL, `FBM_WF_END_SGL,
                           `FBM_WF_LS_SHIFT, `FBM_WF_SS_SHIFT);
            route_d.target = 3'(FBM_T_WORK);
        end else if (i_dual_bank && a >= `FBM_CF_BASE0 && a < `FBM_WF_BASE0) begin
            phys = (a >= `FBM_CF_BASE1) ^ i_map_b;
            route_d = sect(a - ((a >= `FBM_CF_BASE1) ? `FBM_CF_BASE1 : `FBM_CF_BASE0),
                           `FBM_CF_SS_OFS_DUAL, `FBM_CF_END_DUAL,
                           `FBM_CF_LS_SHIFT, `FBM_CF_SS_SHIFT);
            route_d.target = 3'(FBM_T_CODE);
            route_d.bank = phys;
        end else if (i_dual_bank && a >= `FBM_WF_BASE0 && a < `FBM_FLASH_HI) begin
            phys = (a >= `FBM_WF_BASE1) ^ i_map_b;
            route_d = sect(a - ((a >= `FBM_WF_BASE1) ? `FBM_WF_BASE1 : `FBM_WF_BASE0),
                           `FBM_WF_SS_OFS_DUAL, `FBM_WF_END_DUAL,
                           `FBM_WF_LS_SHIFT, `FBM_WF_SS_SHIFT);
            route_d.target = 3'(FBM_T_WORK);
            route_d.bank = phys;
        end else if (a >= `FBM_FLASH_LO && a < `FBM_FLASH_HI) begin
            route_d.bus_error = 1'b1;
        end else begin
            // Outside this map: no target, left to other decoders
            route_d.target = 3'(FBM_T_NONE);
        end
        if (!i_req) begin
            route_d = '0;
        end
    end

    // ============================================================
    // Output registers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            route_q <= '0;
            valid_q <= 1'b0;
        end else begin
            route_q <= route_d;
            valid_q <= valid_d;
        end
    end

    assign o_route = route_q;
    assign o_valid = valid_q;
endmodule : fbm_flash_bank_map

// *** design/fbm_params.svh ***
/*
 Constants for the flash bank address map: region bases, sizes, sector
 geometry and reserved SRAM window. Assumes byte addresses of 32 bits.
*/
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH
// ============================================================
// Region bases, sizes and the reserved SRAM window
`define FBM_ROM_BASE 32'h0000_0000
`define FBM_ROM_SIZE 32'h0000_8000
`define FBM_SRAM_BASE 32'h0800_0000
`define FBM_SRAM_SIZE 32'h0001_0000
`define FBM_SRAM_RSVD 32'h0000_0800
`define FBM_CF_BASE0 32'h1000_0000
`define FBM_CF_BASE1 32'h1200_0000
`define FBM_WF_BASE0 32'h1400_0000
`define FBM_WF_BASE1 32'h1500_0000
`define FBM_FLASH_LO 32'h1000_0000
`define FBM_FLASH_HI 32'h1600_0000
// ============================================================
// Sector geometry (offsets from region base)
`define FBM_CF_SS_OFS_SGL 32'h0007_0000
`define FBM_CF_END_SGL 32'h0009_0000
`define FBM_CF_SS_OFS_DUAL 32'h0003_8000
`define FBM_CF_END_DUAL 32'h0004_8000
`define FBM_WF_SS_OFS_SGL 32'h0000_C000
`define FBM_WF_END_SGL 32'h0001_0000
`define FBM_WF_SS_OFS_DUAL 32'h0000_6000
`define FBM_WF_END_DUAL 32'h0000_8000
`define FBM_CF_LS_SHIFT 15
`define FBM_CF_SS_SHIFT 13
`define FBM_WF_LS_SHIFT 11
`define FBM_WF_SS_SHIFT 7
`endif

// *** design/fbm_pkg.sv ***
/*
 Types for the flash bank address map. Assumes fbm_params.svh beside it.
*/
package fbm_pkg;
    typedef enum {
        FBM_T_NONE, FBM_T_ROM, FBM_T_SRAM, FBM_T_CODE, FBM_T_WORK
    } fbm_target_e;
    typedef struct packed {
        logic [2:0] target;
        logic bank;
        logic large_sector;
        logic [7:0] sector;
        logic [19:0] offset;
        logic bus_error;
    } fbm_route_s;
endpackage : fbm_pkg

// *** verification/fbm_cpu_model.sv ***
/* CPU side model issuing one-cycle address requests.
   Assumes the bench calls issue; drives on falling edges. */
`timescale 1ns/1ps
module fbm_cpu_model (
    input wire logic i_sys_clk,
    output logic o_req = 1'b0,
    output logic [31:0] o_addr = 32'h0
);
    // Released address shows its inverse, so stale values never match
    task automatic issue(input logic [31:0] a);
        @(negedge i_sys_clk);
        o_req = 1'b1;
        o_addr = a;
        @(negedge i_sys_clk);
        o_req = 1'b0;
        o_addr = ~a;
    endtask : issue
endmodule : fbm_cpu_model

// *** verification/fbm_map_sva.sv ***
/* Port checker for the flash bank map.
   Assumes it is bound to the map from the bench. */
`timescale 1ns/1ps
module fbm_map_sva (
    input wire logic i_sys_clk, input wire logic i_srst, input wire logic i_req,
    input wire logic [31:0] i_addr, input wire logic i_user, input wire logic i_dual_bank,
    input wire logic i_map_b, input fbm_pkg::fbm_route_s o_route, input wire logic o_valid
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    wire logic [31:0] a = i_addr;
    wire logic q = i_req & ~i_dual_bank;
    wire logic d = i_req & i_dual_bank;
    cf_single_a: assert property (q && a inside {[32'h1000_0000:32'h1008_FFFF]} |=>
        o_valid && o_route.target == 3'h3 && !o_route.bus_error) else $error("code region lost");
    cf_small_a: assert property (q && a inside {[32'h1007_0000:32'h1008_FFFF]} |=>
        !o_route.large_sector && o_route.sector == 8'(($past(a) - 32'h1007_0000) >> 13)) else $error("small sector");
    wf_small_a: assert property (q && a inside {[32'h1400_C000:32'h1400_FFFF]} |=>
        o_route.target == 3'h4 && o_route.sector == 8'(($past(a) - 32'h1400_C000) >> 7)) else $error("work sector");
    wf_dual_a: assert property (d && a inside {[32'h1500_0000:32'h1500_7FFF]} |=>
        o_route.target == 3'h4 && o_route.bank == !$past(i_map_b)) else $error("work half");
    cf_swap_a: assert property (d && a inside {[32'h1200_0000:32'h1204_7FFF]} |=>
        o_route.target == 3'h3 && o_route.bank == !$past(i_map_b)) else $error("code half");
    hole_err_a: assert property (q && a[31:25] == 7'h09 |=> o_route.bus_error) else $error("no error");
    sram_rsvd_a: assert property (i_req && i_user && a inside {[32'h0800_0000:32'h0800_07FF]} |=>
        o_route.bus_error || o_route.target != 3'h2) else $error("reserved sram reached");
    rom_hit_a: assert property (i_req && a < 32'h0000_8000 |=> o_route.target == 3'h1) else $error("rom");
endmodule : fbm_map_sva

// *** verification/flash_bank_address_map_bench.sv ***
/* Bench: the CPU model issues addresses, t_single, t_dual and t_misc judge the routes.
   Assumes package, design, checker and model compiled first. */
`timescale 1ns/1ps
module flash_bank_address_map_bench;
    logic clk = 1'b0, rst = 1'b1, req, dual = 1'b0, mapb = 1'b0, user = 1'b0, vld;
    logic [31:0] adr;
    fbm_pkg::fbm_route_s r;
    int miscompares = 0, check_count = 0, cyc = 0;
    always #2 clk = ~clk;
    fbm_cpu_model cpu_u (.i_sys_clk(clk), .o_req(req), .o_addr(adr));
    fbm_flash_bank_map dut_u (.i_sys_clk(clk), .i_srst(rst), .i_req(req), .i_addr(adr), .i_user(user),
        .i_dual_bank(dual), .i_map_b(mapb), .o_route(r), .o_valid(vld));
    task automatic chk(string n, logic [19:0] s, x);
        check_count++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    // Expected as {valid, target, bank, large, sector, error}
    task automatic acc(logic [31:0] a, logic [14:0] x);
        cpu_u.issue(a);
        chk("route", {vld, r.target, r.bank, r.large_sector, r.sector, r.bus_error}, x);
    endtask : acc
    task automatic t_single;
        acc(32'h1000_8000, 15'h5A02);
        acc(32'h1008_E000, 15'h581E);
        acc(32'h1400_BFFC, 15'h622E);
        acc(32'h1400_FF80, 15'h60FE);
        cpu_u.issue(32'h1200_0000);
        chk("hole", r.bus_error, 15'h1);
        $display("single bank done");
    endtask : t_single
    task automatic t_dual;
        @(negedge clk) dual = 1'b1;
        acc(32'h1203_8000, 15'h5C00);
        acc(32'h1500_5800, 15'h6616);
        chk("offset", r.offset, 20'h0_5800);
        @(negedge clk) mapb = 1'b1;
        acc(32'h1203_8000, 15'h5800);
        chk("offset", r.offset, 20'h3_8000);
        acc(32'h1400_7F80, 15'h647E);
        cpu_u.issue(32'h1204_8000);
        chk("past end", r.bus_error, 15'h1);
        $display("dual bank done");
    endtask : t_dual
    task automatic t_misc;
        @(negedge clk) user = 1'b1;
        cpu_u.issue(32'h0800_07FC);
        chk("user sram", r.bus_error | (r.target != 3'h2), 15'h1);
        @(negedge clk) user = 1'b0;
        cpu_u.issue(32'h0800_0800);
        chk("sram", r.target, 15'h2);
        cpu_u.issue(32'h0000_7FFC);
        chk("rom", r.target, 15'h1);
        cpu_u.issue(32'h2000_0000);
        chk("outside", {r.target, r.bus_error}, 20'h0);
        @(negedge clk) chk("idle", vld, 15'h0);
        $display("other regions done");
    endtask : t_misc
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Whole run needs about 53 cycles
    always @(posedge clk) if (++cyc == 400) begin
        miscompares++;
        complete_run;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_single;
        t_dual;
        t_misc;
        complete_run;
    end
endmodule : flash_bank_address_map_bench
bind fbm_flash_bank_map fbm_map_sva chk_u (.i_sys_clk, .i_srst, .i_req, .i_addr, .i_user, .i_dual_bank,
    .i_map_b, .o_route, .o_valid);
